// ==== hw/i2sc_seq_ctrl.v ====
// Functional notes
// - ack status flag updated after each transmitted byte
// - ack value bit driven in ack slot
// - ack request runs sequence, then self-clears in master mode; in slave mode it stays set
// - stop request makes stop, then self-clears in master mode; in slave mode it stays set
`timescale 1ns/10ps
`include "i2sc_map.vh"
module i2sc_seq_ctrl (
    // clock and reset
    input  wire        core_clk_i,
    input  wire        arst_n_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    // i2c pins, open drain
    input  wire        scl_i,
    output wire        scl_o,
    output wire        scl_oe_o,
    input  wire        sda_i,
    output wire        sda_o,
    output wire        sda_oe_o,
    // interrupt
    output wire        irq_o
);
    // engine states
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_START = 3'h1;
    localparam [2:0] ST_RST   = 3'h2;
    localparam [2:0] ST_STOP  = 3'h3;
    localparam [2:0] ST_ACK   = 3'h4;
    localparam [2:0] ST_RX    = 3'h5;
    localparam [2:0] ST_TX    = 3'h6;

    reg  [7:0]  seq_q;            // sequence control register
    reg  [1:0]  cfg_q;            // enable and master mode
    reg  [7:0]  baud_q;           // baud reload value
    reg  [7:0]  txd_q;            // transmit byte
    reg  [7:0]  rxd_q;            // received byte
    reg  [2:0]  ist_q;            // sticky irq status
    reg  [2:0]  ien_q;            // irq enable
    reg  [2:0]  st_q;             // engine state
    reg  [1:0]  ph_q;             // quarter phase in a bit
    reg  [3:0]  bit_q;            // bit counter in byte
    reg  [7:0]  div_q;            // quarter-period divider
    reg         scl_low_q;        // drive scl low
    reg         sda_low_q;        // drive sda low
    reg  [1:0]  scl_s_q;          // scl synchroniser
    reg  [1:0]  sda_s_q;          // sda synchroniser
    reg         done_p;           // sequence finished pulse
    reg         byte_p;           // byte finished pulse
    reg         nack_p;           // nack seen pulse

    wire wr      = psel_i & penable_i & pwrite_i;
    wire idle    = (st_q == ST_IDLE);
    wire scl_s   = scl_s_q[1];
    wire sda_s   = sda_s_q[1];
    // a released scl still held low by the far side stretches the phase
    wire hold    = (ph_q == 2'h2) & ~scl_low_q & ~scl_s;
    wire tick    = (div_q == 8'h00) & ~hold;
    wire master  = cfg_q[`I2SC_CFG_MASTER];

    // apb answers at once, no error
    assign pready_o  = 1'b1;
    assign pslverr_o = 1'b0;
    // open drain outputs only pull low
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_o = scl_low_q;
    assign sda_oe_o = sda_low_q;
    assign irq_o    = |(ist_q & ien_q);

    // pin synchronisers
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_i};
            sda_s_q <= {sda_s_q[0], sda_i};
        end
    end

    // read mux, unmapped reads zero
    always @* begin
        case (paddr_i)
            `I2SC_ADDR_SEQ:      prdata_o = {24'h0, seq_q};
            `I2SC_ADDR_CFG:      prdata_o = {30'h0, cfg_q};
            `I2SC_ADDR_RXDATA:   prdata_o = {24'h0, rxd_q};
            `I2SC_ADDR_TXDATA:   prdata_o = {24'h0, txd_q};
            `I2SC_ADDR_IRQ_STAT: prdata_o = {29'h0, ist_q};
            `I2SC_ADDR_IRQ_EN:   prdata_o = {29'h0, ien_q};
            `I2SC_ADDR_BAUD:     prdata_o = {24'h0, baud_q};
            default:             prdata_o = 32'h0;
        endcase
    end

    // config, baud, irq registers
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_q  <= 2'h0;
            baud_q <= `I2SC_RST_BAUD;
            ien_q  <= 3'h0;
            ist_q  <= 3'h0;
        end else begin
            if (wr && paddr_i == `I2SC_ADDR_CFG)
                cfg_q <= pwdata_i[1:0];
            // values below three are dropped
            if (wr && paddr_i == `I2SC_ADDR_BAUD && pwdata_i[7:0] >= `I2SC_BAUD_MIN)
                baud_q <= pwdata_i[7:0];
            if (wr && paddr_i == `I2SC_ADDR_IRQ_EN)
                ien_q <= pwdata_i[2:0];
            // set wins over clear
            ist_q <= (ist_q & ~((wr && paddr_i == `I2SC_ADDR_IRQ_CLR) ?
                      pwdata_i[2:0] : 3'h0)) | {nack_p, byte_p, done_p};
        end
    end

    // sequence engine and control register
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seq_q     <= `I2SC_RST_SEQ;
            txd_q     <= 8'h00;
            rxd_q     <= 8'h00;
            st_q      <= ST_IDLE;
            ph_q      <= 2'h0;
            bit_q     <= 4'h0;
            div_q     <= 8'h00;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            done_p    <= 1'b0;
            byte_p    <= 1'b0;
            nack_p    <= 1'b0;
        end else begin
            done_p <= 1'b0;
            byte_p <= 1'b0;
            nack_p <= 1'b0;
            // divider parks at zero while the clock line is stretched
            div_q  <= tick ? baud_q : (hold && div_q == 8'h00) ? div_q : div_q - 8'h01;
            if (tick)
                ph_q <= ph_q + 2'h1;
            // software writes: plain bits always
            if (wr && paddr_i == `I2SC_ADDR_SEQ) begin
                seq_q[`I2SC_BIT_GCALL]  <= pwdata_i[`I2SC_BIT_GCALL];
                seq_q[`I2SC_BIT_ACKVAL] <= pwdata_i[`I2SC_BIT_ACKVAL];
            end
            // requests only when idle; a refused one leaves the engine stepping
            if (wr && paddr_i == `I2SC_ADDR_SEQ && idle) begin
                seq_q[4:0] <= pwdata_i[4:0];
                ph_q  <= 2'h0;
                div_q <= baud_q;
                bit_q <= 4'h0;
                if (!master)
                    st_q <= ST_IDLE; // slave: start bit is stretch enable
                else if (pwdata_i[`I2SC_BIT_STARTREQ])
                    st_q <= ST_START;
                else if (pwdata_i[`I2SC_BIT_RSTREQ])
                    st_q <= ST_RST;
                else if (pwdata_i[`I2SC_BIT_STOPREQ])
                    st_q <= ST_STOP;
                else if (pwdata_i[`I2SC_BIT_RXREQ])
                    st_q <= ST_RX;
                else if (pwdata_i[`I2SC_BIT_ACKREQ])
                    st_q <= ST_ACK;
            end else if (wr && paddr_i == `I2SC_ADDR_TXDATA && idle && master) begin
                txd_q <= pwdata_i[7:0];
                st_q  <= ST_TX;
                ph_q  <= 2'h0;
                div_q <= baud_q;
                bit_q <= 4'h0;
            end else if (tick) begin
                case (st_q)
                    ST_START, ST_RST: begin
                        // release sda, raise scl, then pull sda then scl low
                        case (ph_q)
                            2'h0:    sda_low_q <= 1'b0;
                            2'h1:    scl_low_q <= 1'b0;
                            2'h2:    sda_low_q <= 1'b1;
                            default: begin
                                scl_low_q <= 1'b1;
                                seq_q[1:0] <= 2'h0;
                                st_q   <= ST_IDLE;
                                done_p <= 1'b1;
                            end
                        endcase
                    end
                    ST_STOP: begin
                        case (ph_q)
                            2'h0:    sda_low_q <= 1'b1;
                            2'h1:    scl_low_q <= 1'b0;
                            2'h2:    sda_low_q <= 1'b0;
                            default: begin
                                seq_q[`I2SC_BIT_STOPREQ] <= 1'b0;
                                st_q   <= ST_IDLE;
                                done_p <= 1'b1;
                            end
                        endcase
                    end
                    ST_ACK: begin
                        // drive ack value for one clock pulse
                        case (ph_q)
                            2'h0:    sda_low_q <= ~seq_q[`I2SC_BIT_ACKVAL];
                            2'h1:    scl_low_q <= 1'b0;
                            2'h2:    scl_low_q <= 1'b1;
                            default: begin
                                sda_low_q <= 1'b0;
                                seq_q[`I2SC_BIT_ACKREQ] <= 1'b0;
                                st_q   <= ST_IDLE;
                                done_p <= 1'b1;
                            end
                        endcase
                    end
                    ST_TX, ST_RX: begin
                        // bits 0..7 data, bit 8 ack slot
                        case (ph_q)
                            2'h0: sda_low_q <= (st_q == ST_TX && bit_q < 4'h8) ?
                                               ~txd_q[7] : 1'b0;
                            2'h1: scl_low_q <= 1'b0;
                            2'h2: begin
                                if (bit_q == 4'h8 && st_q == ST_TX) begin
                                    seq_q[`I2SC_BIT_ACK_STATUS_FLAG] <= sda_s;
                                    nack_p <= sda_s;
                                end else if (bit_q < 4'h8) begin
                                    if (st_q == ST_TX)
                                        txd_q <= {txd_q[6:0], 1'b0};
                                    else
                                        rxd_q <= {rxd_q[6:0], sda_s};
                                end
                            end
                            default: begin
                                scl_low_q <= 1'b1;
                                bit_q <= bit_q + 4'h1;
                                // receive stops before ack slot; ack sent by request
                                if ((st_q == ST_RX && bit_q == 4'h7) || bit_q == 4'h8) begin
                                    sda_low_q <= 1'b0;
                                    seq_q[`I2SC_BIT_RXREQ] <= 1'b0;
                                    st_q   <= ST_IDLE;
                                    byte_p <= 1'b1;
                                end
                            end
                        endcase
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // i2sc_seq_ctrl

// ==== inc/i2sc_map.vh ====
`ifndef I2SC_MAP_VH
`define I2SC_MAP_VH
// register byte addresses
`define I2SC_ADDR_SEQ      12'h000
`define I2SC_ADDR_CFG      12'h004
`define I2SC_ADDR_RXDATA   12'h008
`define I2SC_ADDR_TXDATA   12'h00C
`define I2SC_ADDR_IRQ_STAT 12'h010
`define I2SC_ADDR_IRQ_EN   12'h014
`define I2SC_ADDR_IRQ_CLR  12'h018
`define I2SC_ADDR_BAUD     12'h01C
// sequence control bit positions
`define I2SC_BIT_GCALL     7
`define I2SC_BIT_ACK_STATUS_FLAG   6
`define I2SC_BIT_ACKVAL    5
`define I2SC_BIT_ACKREQ    4
`define I2SC_BIT_RXREQ     3
`define I2SC_BIT_STOPREQ   2
`define I2SC_BIT_RSTREQ    1
`define I2SC_BIT_STARTREQ  0
// config bits
`define I2SC_CFG_EN        0
`define I2SC_CFG_MASTER    1
// irq bits: 0 seq done, 1 byte done, 2 nack seen
`define I2SC_IRQ_W         3
`define I2SC_IRQ_SEQ       0
`define I2SC_IRQ_BYTE      1
`define I2SC_IRQ_NACK      2
// reset values
`define I2SC_RST_SEQ       8'h00
`define I2SC_RST_BAUD      8'h03
`define I2SC_BAUD_MIN      8'h03
`endif

// ==== testbench/i2sc_seq_ctrl_asserts.sv ====
`timescale 1ns/10ps
module i2sc_seq_ctrl_chk (
    input wire logic core_clk_i, arst_n_i, psel_i, penable_i, pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i, prdata_o,
    input wire logic pready_o, pslverr_o, scl_i, scl_o, scl_oe_o,
    input wire logic sda_i, sda_o, sda_oe_o, irq_o
);
    logic       cfg_m_q;   // master mode as last written
    logic       en_nz_q;   // some interrupt enabled
    logic [7:0]  baud_m_q; // baud reload as accepted
    logic [13:0] busy_q;   // clocks left in the running sequence
    wire wr = psel_i & penable_i & pwrite_i;
    wire seq_wr = wr && paddr_i == 12'h000 && busy_q == 14'h0000;
    wire tx_go  = wr && paddr_i == 12'h00C && busy_q == 14'h0000 && cfg_m_q;
    // quarter phases of what starts now: 4 per condition, 32 byte in, 36 byte out
    wire [5:0] phases = tx_go ? 6'h24 : !(seq_wr && cfg_m_q) ? 6'h00 :
        (|pwdata_i[2:0]) ? 6'h04 : pwdata_i[3] ? 6'h20 : pwdata_i[4] ? 6'h04 : 6'h00;
    // shadow of config, enables, baud and a busy count
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_m_q  <= 1'b0;
            en_nz_q  <= 1'b0;
            baud_m_q <= 8'h03;
            busy_q   <= 14'h0000;
        end else begin
            // each quarter phase lasts baud plus one clocks
            if (phases != 6'h00)
                busy_q <= 14'(phases) * (14'(baud_m_q) + 14'h0001);
            else if (busy_q != 14'h0000)
                busy_q <= busy_q - 14'h0001;
            if (wr && paddr_i == 12'h01C && pwdata_i[7:0] >= 8'h03) baud_m_q <= pwdata_i[7:0];
            if (wr && paddr_i == 12'h004) cfg_m_q <= pwdata_i[1];
            if (wr && paddr_i == 12'h014) en_nz_q <= |pwdata_i[2:0];
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    a_start_cond: assert property (seq_wr && pwdata_i[0] && cfg_m_q |->
        ##[1:1000] ($rose(sda_oe_o) && !scl_oe_o)) else $error("no start condition");
    a_restart_cond: assert property (seq_wr && pwdata_i[1] && cfg_m_q |->
        ##[1:1000] ($rose(sda_oe_o) && !scl_oe_o)) else $error("no restart condition");
    a_stop_cond: assert property (seq_wr && pwdata_i[2] && cfg_m_q |->
        ##[1:1000] ($fell(sda_oe_o) && !scl_oe_o)) else $error("no stop condition");
    a_slave_quiet: assert property (seq_wr && pwdata_i[0] && !cfg_m_q |=>
        $stable({sda_oe_o, scl_oe_o})[*8]) else $error("slave start drove pins");
    a_idle_clear: assert property (psel_i && penable_i && !pwrite_i &&
        paddr_i == 12'h000 && cfg_m_q && busy_q == 14'h0000 |-> prdata_o[4:0] == 5'h00)
        else $error("request bit left set when idle");
    a_apb_answer: assert property (psel_i && penable_i |-> pready_o && !pslverr_o)
        else $error("apb answer wrong");
    a_irq_enabled: assert property (irq_o |-> en_nz_q) else $error("irq while masked");
endmodule // i2sc_seq_ctrl_chk
bind i2sc_seq_ctrl i2sc_seq_ctrl_chk u_chk (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .irq_o(irq_o));

// ==== testbench/i2sc_seq_ctrl_bench.sv ====
`timescale 1ns/10ps
`include "i2sc_map.vh"
module i2sc_seq_ctrl_bench;
    logic        clk = 0, rst_n = 0, psel = 0, stop_request = 0, pwr = 0, nack = 0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, rd;
    wire  [31:0] prd;
    wire         scl_oe, sda_oe, slv_oe, scl_o, sda_o, pready, perr, irq;
    wire         scl = !scl_oe;             // open drain, pulled up
    wire         sda = !(sda_oe | slv_oe);  // wired and of both parties
    int          bad_count = 0, checked = 0;
    always #12.5 clk = ~clk;
    i2sc_seq_ctrl u_dut (.core_clk_i(clk), .arst_n_i(rst_n), .psel_i(psel), .penable_i(stop_request),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(pready),
        .pslverr_o(perr), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .irq_o(irq));
    i2sc_slave_model u_slv (.scl_i(scl), .sda_i(sda), .nack_i(nack), .sda_oe_o(slv_oe));
    task summarize;
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1; stop_request <= 0; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        stop_request <= 1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin bad_count++; summarize(); end
        rd = prd;
        psel <= 0;
        stop_request <= 0;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] m, e, input string nm);
        apb(0, a, 0);
        chk(nm, rd & m, e);
    endtask
    // request after the engine has settled
    task req(input logic [31:0] d);
        repeat (40) @(posedge clk);
        apb(1, `I2SC_ADDR_SEQ, d);
    endtask
    // poll until masked bits match, noting any data pull
    task poll(input logic [11:0] a, input logic [31:0] m, e, output logic s);
        int n;
        s = 0; n = 0;
        do begin apb(0, a, 0); s |= sda_oe; n++; end while ((rd & m) !== e && n < 400);
        if (n >= 400) begin bad_count++; summarize(); end
    endtask
    initial begin
        logic s;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        rdc(`I2SC_ADDR_SEQ, 32'hFF, 32'h00, "seq_reset");
        rdc(`I2SC_ADDR_BAUD, 32'hFF, 32'h03, "baud_reset");
        apb(1, `I2SC_ADDR_BAUD, 32'h02);
        rdc(`I2SC_ADDR_BAUD, 32'hFF, 32'h03, "baud_low");
        apb(1, 12'h020, 32'hFFFF);
        rdc(12'h020, 32'hFFFFFFFF, 32'h0, "unmapped");
        $display("test registers done");
        apb(1, `I2SC_ADDR_CFG, 32'h03);
        apb(1, `I2SC_ADDR_IRQ_EN, 32'h07);
        req(32'h01); poll(`I2SC_ADDR_SEQ, 32'h1F, 32'h0, s);
        @(negedge clk); chk("irq_raise", irq, 1);
        apb(1, `I2SC_ADDR_IRQ_EN, 32'h0); @(negedge clk); chk("irq_mask", irq, 0);
        apb(1, `I2SC_ADDR_IRQ_CLR, 32'h7); apb(1, `I2SC_ADDR_IRQ_EN, 32'h7);
        @(negedge clk); chk("irq_clear", irq, 0);
        $display("test start done");
        apb(1, `I2SC_ADDR_TXDATA, 32'hA5); apb(1, `I2SC_ADDR_SEQ, 32'h04);
        rdc(`I2SC_ADDR_SEQ, 32'h04, 32'h0, "busy_stop");
        poll(`I2SC_ADDR_IRQ_STAT, 32'h2, 32'h2, s);
        rdc(`I2SC_ADDR_SEQ, 32'h40, 32'h00, "ack_seen");
        nack <= 1; apb(1, `I2SC_ADDR_IRQ_CLR, 32'h7); apb(1, `I2SC_ADDR_TXDATA, 32'h5A);
        poll(`I2SC_ADDR_IRQ_STAT, 32'h2, 32'h2, s);
        rdc(`I2SC_ADDR_SEQ, 32'h40, 32'h40, "nack_seen");
        rdc(`I2SC_ADDR_IRQ_STAT, 32'h4, 32'h4, "nack_irq");
        $display("test transmit done");
        req(32'h02); poll(`I2SC_ADDR_SEQ, 32'h1F, 32'h0, s);
        req(32'h08); poll(`I2SC_ADDR_SEQ, 32'h1F, 32'h0, s);
        rdc(`I2SC_ADDR_RXDATA, 32'hFF, 32'hFF, "rx_byte");
        req(32'h30); poll(`I2SC_ADDR_SEQ, 32'h1F, 32'h0, s);
        chk("nack_drive", s, 0);
        req(32'h08); poll(`I2SC_ADDR_SEQ, 32'h1F, 32'h0, s);
        req(32'h10); poll(`I2SC_ADDR_SEQ, 32'h1F, 32'h0, s);
        chk("ack_drive", s, 1);
        req(32'h04); poll(`I2SC_ADDR_SEQ, 32'h1F, 32'h0, s);
        chk("bus_free", {sda_oe, scl_oe}, 0);
        chk("pin_level", {sda_o, scl_o}, 0);
        $display("test sequences done");
        apb(1, `I2SC_ADDR_CFG, 32'h01); req(32'h01);
        rdc(`I2SC_ADDR_SEQ, 32'h01, 32'h01, "stretch_bit");
        $display("test slave done");
        summarize();
    end
endmodule // i2sc_seq_ctrl_bench

// ==== testbench/i2sc_slave_model.sv ====
`timescale 1ns/10ps
// far-side slave: acks each byte unless told to refuse
module i2sc_slave_model (
    input  wire logic scl_i,    // resolved clock line
    input  wire logic sda_i,    // resolved data line
    input  wire logic nack_i,   // high: never ack, line left to pull-up
    output logic      sda_oe_o  // high: slave pulls data low
);
    int cnt = 0;  // clock falls since last start
    initial sda_oe_o = 1'b0;
    // start or restart restarts the bit count
    always @(negedge sda_i) begin
        if (scl_i === 1'b1) begin
            cnt = 0;
        end
    end
    // pull data low through the ninth bit slot only
    always @(negedge scl_i) begin
        cnt = cnt + 1;
        sda_oe_o = (cnt % 9 == 0) && !nack_i;
    end
endmodule // i2sc_slave_model
